// >>> rtl/readout_dot_sequencer.sv
// Function
// R1: Dot counter advances by one on each dot request.
// R2: Dot word bit seven low marks the final dot.
// R3: Final dot shown normally; next request latches flag into delayed copy (latched here on the final dot's own request).
// R4: Flag and delayed copy both low clear the dot counter.
// R5: Space: flag low on first word; character advances on next request (advanced here on that first word's own request).
// R6: Low four counter bits select one of sixteen dot words.
// R7: Fifth counter bit ORed with code bit zero drives ROM address four.
// R8: Past sixteen dots the fifth bit selects the next sixteen-word block.
// R9: Horizontal word is five column bits and three dot bits.
// R10: Horizontal word written when request high on 5 MHz falling edge.
// R11: Vertical and mode bits captured on dot request rising edge.
// R12: Line select bit picks bottom or top line; dot bits give height.
// R13: Cursor select low gives character mode with normal routing.
// R14: Cursor select high decodes dot bits five to three into cursors.
// R15: Cursor mode holds until dot bits five and four are both low.
// R16: Voltage cursors route reference levels to the vertical output.
// R17: Time cursors route references horizontally, converter vertically.
// R18: ROM address holds character code high and dot counter low.
// R19: Character counter steps on the request after the final-dot flag (stepped here on the final dot's own request).
// R20: Request edges detected synchronously, used as enables.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "dot_seq_params.svh"
module readout_dot_sequencer (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        dot_request,
  input  wire logic                        clk_5mhz,
  input  wire logic [7:0]                  char_code,
  input  wire logic [7:0]                  dot_word,
  output logic      [6:0]                  char_addr,
  output logic      [11:0]                 rom_addr,
  output logic      [7:0]                  hdac_data,
  output logic                             hdac_write,
  output logic      [4:0]                  vdac_data,
  output dot_seq_pkg::disp_mode_type       disp_mode,
  output dot_seq_pkg::defl_src_type        horiz_src,
  output dot_seq_pkg::defl_src_type        vert_src
);
  import dot_seq_pkg::*;

  seq_state_type st_ff;
  seq_state_type nxt_st;
  logic          dreq_rise;
  logic          clk5_fall;
  logic          end_of_char_n;
  logic          dot_cnt_clear;
  logic          step;
  logic          wr_ctrl;
  logic          addr_err;
  logic [31:0]   rdata;
  mode_if        mif ();

  // ==========================================================
  // Edge detection on the slow strobes
  // R20 synchronous edges
  edge_detect u_dreq_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (dot_request),
    .rise    (dreq_rise),
    .fall    ()
  );

  // R20 synchronous edges
  edge_detect u_clk5_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (clk_5mhz),
    .rise    (),
    .fall    (clk5_fall)
  );

  mode_decoder u_mode (
    .pclk    (pclk),
    .presetn (presetn),
    .mif     (mif)
  );

  // ==========================================================
  // Dot and character sequencing
  // R2 final dot flag
  assign end_of_char_n = dot_word[`LAST_DOT_FLAG_BIT];
  // R4 counter clear term
  // The delayed copy goes low only a cycle after this request, so the step term clears at once
  assign dot_cnt_clear = ~end_of_char_n & (step | ~st_ff.end_of_char_delayed_n);
  assign step          = dreq_rise & st_ff.run;
  assign wr_ctrl       = psel & penable & pwrite & (paddr == `REG_CTRL_OFS);

  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.hwr = 1'b0;
    if (wr_ctrl)
      nxt_st.run = pwdata[`CTRL_RUN_BIT];
    if (step)
    begin
      // R1 dot advance
      nxt_st.dot_cnt = st_ff.dot_cnt + 5'h01;
      // R3 delayed flag
      nxt_st.end_of_char_delayed_n = end_of_char_n;
      // R11 vertical capture
      nxt_st.vpos = {st_ff.char_cnt[5], dot_word[6:3]};
      // R9 horizontal word of the same dot, held for the strobe
      nxt_st.hpos = {st_ff.char_cnt[4:0], dot_word[2:0]};
      // R19 next character
      if (!end_of_char_n)
        nxt_st.char_cnt = st_ff.char_cnt + 7'h01;
    end
    // R10 horizontal write strobe
    if (st_ff.run && dot_request && clk5_fall)
      nxt_st.hwr = 1'b1;
    // R4 end of character
    if (dot_cnt_clear)
      nxt_st.dot_cnt = `DOT_CNT_RESET;
    // Software clear wins so a restart always begins at dot zero
    if (wr_ctrl && pwdata[`CTRL_CLEAR_BIT])
    begin
      nxt_st.dot_cnt               = `DOT_CNT_RESET;
      nxt_st.char_cnt              = `CHAR_CNT_RESET;
      nxt_st.end_of_char_delayed_n = `EOCD_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff.run                   <= `CTRL_RUN_RESET;
      st_ff.dot_cnt               <= `DOT_CNT_RESET;
      st_ff.char_cnt              <= `CHAR_CNT_RESET;
      st_ff.end_of_char_delayed_n <= `EOCD_RESET;
      st_ff.vpos                  <= `VPOS_RESET;
      st_ff.hpos                  <= `HPOS_RESET;
      st_ff.hwr                   <= 1'b0;
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================
  // Pin outputs
  // R18 ROM address
  // R7 large character bit
  assign rom_addr   = {char_code[7:1], char_code[0] | st_ff.dot_cnt[4],
                       st_ff.dot_cnt[3:0]};
  assign char_addr  = st_ff.char_cnt;
  // R9 horizontal word
  assign hdac_data  = st_ff.hpos;
  assign hdac_write = st_ff.hwr;
  // R12 line and height
  assign vdac_data  = st_ff.vpos;

  // ==========================================================
  // Mode select
  // R13 cursor select latch
  assign mif.sample            = step;
  assign mif.cursor_select_bit = st_ff.char_cnt[6];
  assign mif.dd_latched        = st_ff.vpos[2:0];
  assign disp_mode             = mif.mode;
  assign horiz_src             = mif.hsrc;
  assign vert_src              = mif.vsrc;

  // ==========================================================
  // APB slave, zero wait states; unmapped offsets flag an error
  always_comb
  begin
    rdata    = 32'h0000_0000;
    addr_err = 1'b0;
    case (paddr)
      `REG_CTRL_OFS:
        rdata[`CTRL_RUN_BIT] = st_ff.run;
      `REG_STATUS_OFS:
      begin
        rdata[`STAT_DOT_LSB +: 5]  = st_ff.dot_cnt;
        rdata[`STAT_CHAR_LSB +: 7] = st_ff.char_cnt;
        rdata[`STAT_EOCD_BIT]      = st_ff.end_of_char_delayed_n;
        rdata[`STAT_MODE_LSB +: 3] = mif.mode;
        rdata[`STAT_SEL_BIT]       = mif.sel;
      end
      `REG_POSITION_OFS:
      begin
        rdata[`POS_HPOS_LSB +: 8] = st_ff.hpos;
        rdata[`POS_VPOS_LSB +: 5] = st_ff.vpos;
      end
      `REG_ROM_ADDR_OFS:
        rdata[11:0] = rom_addr;
      default:
        addr_err = 1'b1;
    endcase
  end

  assign prdata  = (psel && !pwrite) ? rdata : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & addr_err;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_last_dot_taken;
    step && !end_of_char_n && !wr_ctrl;
  endsequence

  sequence s_plain_step;
    step && !dot_cnt_clear && !wr_ctrl;
  endsequence

  property p_dot_advance;
    s_plain_step |=> st_ff.dot_cnt == $past(st_ff.dot_cnt) + 5'h01;
  endproperty
  a_dot_advance: assert property (p_dot_advance) // R1
    else $error("dot counter did not advance on request");

  property p_delay_latch;
    (step && !wr_ctrl) |=>
      st_ff.end_of_char_delayed_n == $past(dot_word[7]);
  endproperty
  a_delay_latch: assert property (p_delay_latch) // R3
    else $error("delayed end flag not latched");

  property p_dot_clear;
    s_last_dot_taken |=> st_ff.dot_cnt == `DOT_CNT_RESET;
  endproperty
  a_dot_clear: assert property (p_dot_clear) // R4
    else $error("dot counter not cleared after final dot");

  property p_char_step;
    s_last_dot_taken |=> st_ff.char_cnt == $past(st_ff.char_cnt) + 7'h01;
  endproperty
  a_char_step: assert property (p_char_step) // R19
    else $error("character counter did not step");

  property p_space_char;
    s_last_dot_taken ##1 (!end_of_char_n && !step && !wr_ctrl)
      |=> st_ff.dot_cnt == `DOT_CNT_RESET && $stable(st_ff.char_cnt);
  endproperty
  a_space_char: assert property (p_space_char) // R5
    else $error("space character mishandled");

  property p_low_bits;
    (s_plain_step and (rom_addr[3:0] != 4'hF)) |=>
      rom_addr[3:0] == $past(rom_addr[3:0]) + 4'h1;
  endproperty
  a_low_bits: assert property (p_low_bits) // R6
    else $error("low ROM address bits did not step");

  property p_block_bit;
    rom_addr[4] == (char_code[0] | st_ff.dot_cnt[4]) &&
    rom_addr[11:5] == char_code[7:1];
  endproperty
  a_block_bit: assert property (p_block_bit) // R7
    else $error("ROM block address wrong");

  property p_large_char;
    (s_plain_step and (st_ff.dot_cnt == 5'h0F)) |=>
      st_ff.dot_cnt[4] && rom_addr[4] && rom_addr[3:0] == 4'h0;
  endproperty
  a_large_char: assert property (p_large_char) // R8
    else $error("large character did not enter second block");

  property p_hdac_write;
    (st_ff.run && dot_request && clk5_fall && !step) |=> hdac_write &&
      $stable(hdac_data);
  endproperty
  a_hdac_write: assert property (p_hdac_write) // R10
    else $error("horizontal word not written");

  property p_vert_latch;
    step |=> vdac_data == {$past(st_ff.char_cnt[5]), $past(dot_word[6:3])} &&
      hdac_data == {$past(st_ff.char_cnt[4:0]), $past(dot_word[2:0])};
  endproperty
  a_vert_latch: assert property (p_vert_latch) // R11
    else $error("vertical bits not captured");

  property p_char_mode;
    !mif.sel |-> disp_mode == MODE_CHAR &&
      horiz_src == SRC_HDAC && vert_src == SRC_VDAC;
  endproperty
  a_char_mode: assert property (p_char_mode) // R13
    else $error("character mode routing wrong");

  property p_cursor_hold;
    (step && mif.sel && (mif.dd_latched[2:1] != 2'b00)) |=> mif.sel;
  endproperty
  a_cursor_hold: assert property (p_cursor_hold) // R15
    else $error("cursor mode dropped early");

  property p_cursor_exit;
    (step && mif.sel && (mif.dd_latched[2:1] == 2'b00)) |=>
      mif.sel == $past(st_ff.char_cnt[6]);
  endproperty
  a_cursor_exit: assert property (p_cursor_exit) // R15
    else $error("cursor select not resampled");

  property p_volt_cursor;
    (mif.sel && mif.dd_latched == 3'b100) |->
      disp_mode == MODE_VCUR0 && vert_src == SRC_REF0 && horiz_src == SRC_HDAC;
  endproperty
  a_volt_cursor: assert property (p_volt_cursor) // R16
    else $error("voltage cursor routing wrong");

  property p_time_cursor;
    (mif.sel && mif.dd_latched == 3'b011) |->
      disp_mode == MODE_HCUR1 && horiz_src == SRC_REF1 && vert_src == SRC_HDAC;
  endproperty
  a_time_cursor: assert property (p_time_cursor) // R17
    else $error("time cursor routing wrong");

endmodule

// >>> rtl/dot_seq_params.svh
`ifndef DOT_SEQ_PARAMS_SVH
`define DOT_SEQ_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses, one 32-bit word each)
`define REG_CTRL_OFS      8'h00
`define REG_STATUS_OFS    8'h04
`define REG_POSITION_OFS  8'h08
`define REG_ROM_ADDR_OFS  8'h0C

// ==========================================================
// Control register fields
`define CTRL_RUN_BIT      0
`define CTRL_CLEAR_BIT    1
`define CTRL_RUN_RESET    1'b0

// ==========================================================
// Status and position register fields
`define STAT_DOT_LSB      0
`define STAT_CHAR_LSB     8
`define STAT_EOCD_BIT     16
`define STAT_MODE_LSB     20
`define STAT_SEL_BIT      24
`define POS_HPOS_LSB      0
`define POS_VPOS_LSB      8

// ==========================================================
// Dot word layout and counter resets
`define LAST_DOT_FLAG_BIT 7
`define DOT_CNT_RESET     5'h00
`define CHAR_CNT_RESET    7'h00
`define EOCD_RESET        1'b1
`define HPOS_RESET        8'h00
`define VPOS_RESET        5'h00

`endif

// >>> rtl/dot_seq_pkg.sv
package dot_seq_pkg;

  // ==========================================================
  // Display modes and deflection sources
  typedef enum logic [2:0] {
    MODE_CHAR   = 3'b000,
    MODE_VCUR1  = 3'b001,
    MODE_HCUR1  = 3'b010,
    MODE_VCUR0  = 3'b011,
    MODE_HCUR0  = 3'b100,
    MODE_RETURN = 3'b101
  } disp_mode_type;

  typedef enum logic [1:0] {
    SRC_HDAC = 2'b00,
    SRC_VDAC = 2'b01,
    SRC_REF0 = 2'b10,
    SRC_REF1 = 2'b11
  } defl_src_type;

  // ==========================================================
  // Per-module state
  typedef struct packed {
    logic prev;
  } edge_state_type;

  typedef struct packed {
    logic sel;
  } mode_state_type;

  typedef struct packed {
    logic       run;
    logic [4:0] dot_cnt;
    logic [6:0] char_cnt;
    logic       end_of_char_delayed_n;
    logic [4:0] vpos;
    logic [7:0] hpos;
    logic       hwr;
  } seq_state_type;

endpackage

// >>> rtl/mode_if.sv
`timescale 1ns/1ps
interface mode_if;
  import dot_seq_pkg::*;

  logic          sample;
  logic          cursor_select_bit;
  logic [2:0]    dd_latched;
  logic          sel;
  disp_mode_type mode;
  defl_src_type  hsrc;
  defl_src_type  vsrc;

  modport seq (
    output sample, cursor_select_bit, dd_latched,
    input  sel, mode, hsrc, vsrc
  );
  modport dec (
    input  sample, cursor_select_bit, dd_latched,
    output sel, mode, hsrc, vsrc
  );
endinterface

// >>> rtl/edge_detect.sv
`timescale 1ns/1ps
module edge_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  import dot_seq_pkg::*;

  edge_state_type st_ff;
  edge_state_type nxt_st;

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.prev = level;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign rise = level & ~st_ff.prev;
  assign fall = ~level & st_ff.prev;
endmodule

// >>> rtl/mode_decoder.sv
`timescale 1ns/1ps
module mode_decoder (
  input  wire logic pclk,
  input  wire logic presetn,
  mode_if.dec       mif
);
  import dot_seq_pkg::*;

  mode_state_type st_ff;
  mode_state_type nxt_st;

  // ==========================================================
  // Cursor select latch
  always_comb
  begin
    nxt_st = st_ff;
    if (mif.sample)
    begin
      // R15 hold in cursor
      if (st_ff.sel && (mif.dd_latched[2:1] != 2'b00))
        nxt_st.sel = 1'b1;
      else
        nxt_st.sel = mif.cursor_select_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // ==========================================================
  // Mode decode and deflection routing
  always_comb
  begin
    mif.mode = MODE_CHAR;
    mif.hsrc = SRC_HDAC;
    mif.vsrc = SRC_VDAC;
    if (st_ff.sel)
    begin
      // R14 cursor decode
      case (mif.dd_latched)
        3'b010:
        begin
          mif.mode = MODE_VCUR1;
          mif.vsrc = SRC_REF1;
        end
        3'b011:
        begin
          mif.mode = MODE_HCUR1;
          mif.hsrc = SRC_REF1;
          mif.vsrc = SRC_HDAC;
        end
        3'b100:
        begin
          mif.mode = MODE_VCUR0;
          mif.vsrc = SRC_REF0;
        end
        3'b101:
        begin
          mif.mode = MODE_HCUR0;
          mif.hsrc = SRC_REF0;
          mif.vsrc = SRC_HDAC;
        end
        3'b000,
        3'b001:  mif.mode = MODE_RETURN;
        default: mif.mode = MODE_CHAR;
      endcase
    end
  end

  assign mif.sel = st_ff.sel;
endmodule

// >>> bench/dot_rom_pkg.sv
package dot_rom_pkg;

  // Spaces every eighth cell, one large glyph, the rest short glyphs
  function automatic logic [7:0] code_of(input logic [6:0] a);
    case (a[2:0])
      3'd0:    return 8'h00;
      3'd2:    return 8'h04;
      default: return {a[6:2], 3'b111};
    endcase
  endfunction

  // Block 4 and 5 form one 20-dot glyph; word bit 7 low on the last dot
  function automatic logic [7:0] word_of(input logic [11:0] ad);
    logic [7:0] blk;
    logic [4:0] idx;
    logic [4:0] last;
    logic [6:0] pos;
    blk  = ad[11:4];
    idx  = {blk == 8'h05, ad[3:0]};
    last = (blk == 8'h00) ? 5'd0 : (blk[7:1] == 7'h02) ? 5'd19 : {3'b000, blk[4:3]} + 5'd1;
    pos  = {2'b00, idx} * 7'd13 + blk[6:0];
    return {idx != last, pos};
  endfunction

endpackage

// >>> bench/dot_source_model.sv
`timescale 1ns/1ps
module dot_source_model
  import dot_rom_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        enable,
  input  wire logic [3:0]  gap,
  input  wire logic [6:0]  char_addr,
  input  wire logic [11:0] rom_addr,
  output logic             dot_request,
  output logic             clk_5mhz,
  output logic [7:0]       char_code,
  output logic [7:0]       dot_word
);
  logic [4:0] phase_ff;
  logic [3:0] wait_ff;
  logic       prev_ff;

  // ==========================================================
  // Character memory and glyph store answer combinationally
  assign char_code = code_of(char_addr);
  assign dot_word  = word_of(rom_addr);

  // ==========================================================
  // Dot cycle generator
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_ff    <= 5'd0;
      clk_5mhz    <= 1'b1;
      prev_ff     <= 1'b1;
      dot_request <= 1'b0;
      wait_ff     <= 4'd0;
    end
    else
    begin
      phase_ff <= (phase_ff == 5'd19) ? 5'd0 : phase_ff + 5'd1;
      clk_5mhz <= (phase_ff < 5'd9) || (phase_ff == 5'd19);
      prev_ff  <= clk_5mhz;
      // Released at the sampled 5 MHz fall, so each request sees exactly one
      if (dot_request)
      begin
        if (!clk_5mhz && prev_ff)
        begin
          dot_request <= 1'b0;
          wait_ff     <= gap;
        end
      end
      else if (wait_ff != 4'd0)
        wait_ff <= wait_ff - 4'd1;
      else if (enable && clk_5mhz && phase_ff < 5'd4)
        dot_request <= 1'b1;
    end
  end
endmodule

// >>> bench/readout_dot_sequencer_test.sv
`timescale 1ns/1ps
`include "dot_seq_params.svh"
module readout_dot_sequencer_test;
  import dot_seq_pkg::*;
  import dot_rom_pkg::*;

  typedef struct packed {
    logic [7:0] hpos;
    logic [4:0] vpos;
    logic [6:0] route;
    logic [6:0] chr;
  } note_type;

  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]    paddr, char_code, dot_word, hdac_data;
  logic [31:0]   pwdata, prdata, seed, rd;
  logic          dot_request, clk_5mhz, hdac_write, enable;
  logic [6:0]    char_addr, m_char;
  logic [11:0]   rom_addr;
  logic [4:0]    vdac_data, m_cnt, m_vpos;
  logic [3:0]    gap;
  logic          m_del, m_sel, m_rq, m_run;
  disp_mode_type disp_mode;
  defl_src_type  horiz_src, vert_src;
  note_type      notes[$];
  int            bad_count, num_checks, cycles;

  readout_dot_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dot_request(dot_request), .clk_5mhz(clk_5mhz),
    .char_code(char_code), .dot_word(dot_word), .char_addr(char_addr), .rom_addr(rom_addr),
    .hdac_data(hdac_data), .hdac_write(hdac_write), .vdac_data(vdac_data),
    .disp_mode(disp_mode), .horiz_src(horiz_src), .vert_src(vert_src));

  dot_source_model i_far (.pclk(pclk), .presetn(presetn), .enable(enable), .gap(gap),
    .char_addr(char_addr), .rom_addr(rom_addr), .dot_request(dot_request),
    .clk_5mhz(clk_5mhz), .char_code(char_code), .dot_word(dot_word));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [11:0] exp_addr(input logic [6:0] c, input logic [4:0] n);
    logic [7:0] code;
    code = code_of(c);
    return {code[7:1], code[0] | n[4], n[3:0]};
  endfunction

  function automatic logic [6:0] exp_route(input logic s, input logic [2:0] d);
    if (!s)
      return {MODE_CHAR, SRC_HDAC, SRC_VDAC};
    case (d)
      3'b010:         return {MODE_VCUR1, SRC_HDAC, SRC_REF1};
      3'b011:         return {MODE_HCUR1, SRC_REF1, SRC_HDAC};
      3'b100:         return {MODE_VCUR0, SRC_HDAC, SRC_REF0};
      3'b101:         return {MODE_HCUR0, SRC_REF0, SRC_HDAC};
      3'b000, 3'b001: return {MODE_RETURN, SRC_HDAC, SRC_VDAC};
      default:        return {MODE_CHAR, SRC_HDAC, SRC_VDAC};
    endcase
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] data, output logic fault);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge pclk);
    end
    data = prdata;
    fault = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Random request spacing and run time limit
  always @(posedge pclk)
  begin
    seed   <= xorshift(seed);
    gap    <= 4'h2 + {1'b0, seed[2:0]};
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      bad_count++;
      $display("ERROR run time expected 60000 seen %0d", cycles);
      report_and_stop;
    end
  end

  // ==========================================================
  // Reference sequencer: steps on each request rise, notes the dot
  // Runs on the falling edge so the counters are seen before the request edge
  always @(negedge pclk)
  begin : ref_model
    logic [7:0] w;
    logic       hold;
    w = word_of(exp_addr(m_char, m_cnt));
    if (!presetn)
    begin
      m_cnt  = 5'h00;
      m_char = 7'h00;
      m_del  = 1'b1;
      m_sel  = 1'b0;
      m_vpos = 5'h00;
    end
    else if (dot_request && !m_rq && m_run)
    begin
      chk("rom_addr", {20'h0, exp_addr(m_char, m_cnt)}, {20'h0, rom_addr});
      hold = m_sel && (m_vpos[2:1] != 2'b00);
      if (!hold)
        m_sel = m_char[6];
      m_vpos = {m_char[5], w[6:3]};
      notes.push_back('{{m_char[4:0], w[2:0]}, m_vpos, exp_route(m_sel, m_vpos[2:0]),
                        m_char + {6'h00, ~w[7]}});
      m_del  = w[7];
      m_char = m_char + {6'h00, ~w[7]};
      m_cnt  = w[7] ? m_cnt + 5'h01 : 5'h00;
    end
    m_rq = dot_request;
  end

  // ==========================================================
  // Output watcher: each converter write consumes the oldest note
  always @(negedge pclk)
  begin : watcher
    note_type n;
    if (hdac_write === 1'b1)
    begin
      if (notes.size() == 0)
        chk("hdac_write", 32'h0, 32'h1);
      else
      begin
        n = notes.pop_front();
        chk("hdac_data", {24'h0, n.hpos}, {24'h0, hdac_data});
        chk("vdac_data", {27'h0, n.vpos}, {27'h0, vdac_data});
        chk("routing", {25'h0, n.route}, {25'h0, disp_mode, horiz_src, vert_src});
        chk("char_addr", {25'h0, n.chr}, {25'h0, char_addr});
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    enable = 1'b0;
    m_run = 1'b0;
    m_rq = 1'b0;
    seed = 32'h4C7A3E94;
    gap = 4'h2;
    cycles = 0;
    bad_count = 0;
    num_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `REG_STATUS_OFS, 32'h0, rd, err);
    chk("status", 32'h0001_0000, rd);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF, rd, err);
    chk("unmapped fault", 32'h1, {31'h0, err});
    apb(1'b1, `REG_CTRL_OFS, 32'h1, rd, err);
    m_run = 1'b1;
    apb(1'b0, `REG_CTRL_OFS, 32'h0, rd, err);
    chk("ctrl", 32'h1, rd);
    $display("test registers done");
    enable <= 1'b1;
    wait (m_char == 7'h7F);
    wait (m_char == 7'h00);
    enable <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("pending writes", 32'h0, 32'(notes.size()));
    apb(1'b0, `REG_STATUS_OFS, 32'h0, rd, err);
    chk("dot count", {27'h0, m_cnt}, {27'h0, rd[4:0]});
    chk("char count", {25'h0, m_char}, {25'h0, rd[14:8]});
    chk("delayed flag", {31'h0, m_del}, {31'h0, rd[16]});
    apb(1'b0, `REG_ROM_ADDR_OFS, 32'h0, rd, err);
    chk("rom address", {20'h0, exp_addr(m_char, m_cnt)}, rd);
    $display("test traffic done");
    apb(1'b1, `REG_CTRL_OFS, 32'h3, rd, err);
    apb(1'b0, `REG_STATUS_OFS, 32'h0, rd, err);
    chk("cleared status", 32'h0001_0000, rd & 32'h0001_7F1F);
    $display("test clear done");
    report_and_stop;
  end
endmodule
